// ===== adc_cfg_top.sv
// Package and top module of the converter pin, scan and clock configuration block
// Overview of operation
// - A set mode bit makes the matching analog pin digital and opens its port read path.
// - A clear mode bit makes the pin analog, blocks its port read and lets the converter sample it.
// - Sixteen mode bits are held, bit n belonging to the pin of analog channel n.
// - Sixteen scan selection bits are held, bit n belonging to analog channel n.
// - A channel whose scan selection bit is set takes part in the automatic scan.
// - A channel whose scan selection bit is clear is skipped by the automatic scan.
// - On the system clock the conversion clock period is the instruction period times divisor plus one.
// - The instruction clock counts as two oscillator periods, with no clock reduction or multiplier.
// - A set clock source bit takes the conversion clock from the internal RC, a clear one from the system clock.
package adc_cfg_pkg;
	localparam int          NUM_CH          = 16;
	localparam int          CH_W            = 4;
	localparam int          ADDR_W          = 4;
	// Byte addresses of the word registers
	localparam logic [3:0]  PIN_MODE_ADDR   = 4'h0;
	localparam logic [3:0]  SCAN_SEL_ADDR   = 4'h4;
	localparam logic [3:0]  CLK_CTRL_ADDR   = 4'h8;
	localparam logic [3:0]  SCAN_CTRL_ADDR  = 4'hc;
	// Clock control fields
	localparam int          CLK_SRC_BIT     = 15;
	localparam int          DIV_LSB         = 0;
	localparam int          DIV_W           = 8;
	// Scan control fields
	localparam int          SCAN_EN_BIT     = 0;
	localparam int          SCAN_VALID_BIT  = 1;
	localparam int          SCAN_CH_LSB     = 4;
	// Reset values
	localparam logic [15:0] PIN_MODE_RST    = 16'h0000;
	localparam logic [15:0] SCAN_SEL_RST    = 16'h0000;
	localparam logic [7:0]  DIV_RST         = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
	// Instruction cycle in oscillator periods
	localparam int          OSC_PER_INSTR   = 2;
	// Instruction clock at 40 MHz, period in ns
	localparam int          INSTR_PERIOD_NS = 25;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;
endpackage

`timescale 1ns/1ps
`default_nettype none

module adc_cfg_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Digital port
	input  wire logic [15:0] port_pin_in,
	output logic      [15:0] port_read_data,
	output logic      [15:0] digital_read_en,
	// Converter core
	input  wire logic        rc_clk_tick,
	input  wire logic        scan_advance,
	output logic      [15:0] analog_sample_en,
	output logic             conv_clk_tick,
	output logic             conv_clk_source,
	output logic      [3:0]  scan_channel,
	output logic             scan_valid
);
	adc_cfg_pkg::bus_state_e bus_state_r, bus_state_nxt;
	logic [15:0] pin_mode_r, pin_mode_nxt;
	logic [15:0] scan_sel_r, scan_sel_nxt;
	logic [7:0]  div_r, div_nxt;
	logic        src_r, src_nxt;
	logic        scan_en_r, scan_en_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        wait_r, wait_nxt;
	logic [7:0]  cnt_r, cnt_nxt;
	logic        tick_r, tick_nxt;
	logic [15:0] port_r, port_nxt;
	logic [15:0] dig_en_r, dig_en_nxt;
	logic [15:0] ana_en_r, ana_en_nxt;
	logic        scan_start;
	logic [3:0]  seq_ch;
	logic        seq_valid;
	logic        take;

	// A request is served once, at the edge that sees waitrequest low
	assign take = (read || write) && (bus_state_r == adc_cfg_pkg::BUS_ACK);

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	always_comb begin
		bus_state_nxt = bus_state_r;
		pin_mode_nxt  = pin_mode_r;
		scan_sel_nxt  = scan_sel_r;
		div_nxt       = div_r;
		src_nxt       = src_r;
		scan_en_nxt   = scan_en_r;
		rdata_nxt     = rdata_r;
		wait_nxt      = 1'b1;
		case (bus_state_r)
			adc_cfg_pkg::BUS_IDLE: begin
				if (read || write) begin
					bus_state_nxt = adc_cfg_pkg::BUS_ACK;
					wait_nxt      = 1'b0;
					rdata_nxt     = adc_cfg_pkg::UNMAPPED_DATA;
					case (address)
						adc_cfg_pkg::PIN_MODE_ADDR: rdata_nxt[15:0] = pin_mode_r;
						adc_cfg_pkg::SCAN_SEL_ADDR: rdata_nxt[15:0] = scan_sel_r;
						adc_cfg_pkg::CLK_CTRL_ADDR: begin
							rdata_nxt[adc_cfg_pkg::CLK_SRC_BIT] = src_r;
							rdata_nxt[adc_cfg_pkg::DIV_LSB +: adc_cfg_pkg::DIV_W] = div_r;
						end
						adc_cfg_pkg::SCAN_CTRL_ADDR: begin
							rdata_nxt[adc_cfg_pkg::SCAN_EN_BIT]    = scan_en_r;
							rdata_nxt[adc_cfg_pkg::SCAN_VALID_BIT] = seq_valid;
							rdata_nxt[adc_cfg_pkg::SCAN_CH_LSB +: adc_cfg_pkg::CH_W] = seq_ch;
						end
						default: rdata_nxt = adc_cfg_pkg::UNMAPPED_DATA;
					endcase
				end
			end
			adc_cfg_pkg::BUS_ACK: begin
				bus_state_nxt = adc_cfg_pkg::BUS_IDLE;
				if (write) begin
					case (address)
						adc_cfg_pkg::PIN_MODE_ADDR:
							pin_mode_nxt = merge16(pin_mode_r, writedata, byteenable);
						adc_cfg_pkg::SCAN_SEL_ADDR:
							scan_sel_nxt = merge16(scan_sel_r, writedata, byteenable);
						adc_cfg_pkg::CLK_CTRL_ADDR: begin
							if (byteenable[0]) begin
								div_nxt = writedata[adc_cfg_pkg::DIV_LSB +: adc_cfg_pkg::DIV_W];
							end
							if (byteenable[1]) begin
								src_nxt = writedata[adc_cfg_pkg::CLK_SRC_BIT];
							end
						end
						adc_cfg_pkg::SCAN_CTRL_ADDR: begin
							if (byteenable[0]) begin
								scan_en_nxt = writedata[adc_cfg_pkg::SCAN_EN_BIT];
							end
						end
						default: begin
						end
					endcase
				end
			end
			default: bus_state_nxt = adc_cfg_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_state_r <= adc_cfg_pkg::BUS_IDLE;
			pin_mode_r  <= adc_cfg_pkg::PIN_MODE_RST;
			scan_sel_r  <= adc_cfg_pkg::SCAN_SEL_RST;
			div_r       <= adc_cfg_pkg::DIV_RST;
			src_r       <= 1'b0;
			scan_en_r   <= 1'b0;
			rdata_r     <= 32'h00000000;
			wait_r      <= 1'b1;
		end else begin
			bus_state_r <= bus_state_nxt;
			pin_mode_r  <= pin_mode_nxt;
			scan_sel_r  <= scan_sel_nxt;
			div_r       <= div_nxt;
			src_r       <= src_nxt;
			scan_en_r   <= scan_en_nxt;
			rdata_r     <= rdata_nxt;
			wait_r      <= wait_nxt;
		end
	end

	// The instruction clock is ref_clk itself, already two oscillator periods per cycle,
	// so the divisor counts ref_clk cycles directly.
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (src_r) begin
			cnt_nxt  = 8'h00;
			tick_nxt = rc_clk_tick;
		end else if (cnt_r >= div_r) begin
			cnt_nxt  = 8'h00;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_r  <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// Analog pins read back zero on the port so a floating level never reaches software
	always_comb begin
		dig_en_nxt = pin_mode_r;
		ana_en_nxt = ~pin_mode_r;
		port_nxt   = port_pin_in & pin_mode_r;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dig_en_r <= 16'h0000;
			ana_en_r <= 16'h0000;
			port_r   <= 16'h0000;
		end else begin
			dig_en_r <= dig_en_nxt;
			ana_en_r <= ana_en_nxt;
			port_r   <= port_nxt;
		end
	end

	assign scan_start = take && write && (address == adc_cfg_pkg::SCAN_CTRL_ADDR) && byteenable[0];

	scan_sequencer u_scan (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.scan_sel     (scan_sel_r),
		.scan_en      (scan_en_r),
		.restart      (scan_start),
		.advance      (scan_advance),
		.channel      (seq_ch),
		.channel_valid(seq_valid)
	);

	assign readdata         = rdata_r;
	assign waitrequest      = wait_r;
	assign port_read_data   = port_r;
	assign digital_read_en  = dig_en_r;
	assign analog_sample_en = ana_en_r;
	assign conv_clk_tick    = tick_r;
	assign conv_clk_source  = src_r;
	assign scan_channel     = seq_ch;
	assign scan_valid       = seq_valid;
endmodule // adc_cfg_top

`default_nettype wire

// ===== scan_sequencer.sv
// Channel scan sequencer stepping through the selected analog channels
`timescale 1ns/1ps
`default_nettype none

module scan_sequencer (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Control
	input  wire logic [15:0] scan_sel,
	input  wire logic        scan_en,
	input  wire logic        restart,
	input  wire logic        advance,
	// Current channel
	output logic      [3:0]  channel,
	output logic             channel_valid
);
	logic [3:0] ch_r, ch_nxt;
	logic       valid_r, valid_nxt;
	logic [3:0] lowest;
	logic [3:0] above;
	logic       has_any;
	logic       has_above;

	// Search both the lowest selected channel and the next one above the current
	always_comb begin
		lowest    = 4'h0;
		above     = 4'h0;
		has_any   = 1'b0;
		has_above = 1'b0;
		for (int i = adc_cfg_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (scan_sel[i]) begin
				lowest  = 4'(i);
				has_any = 1'b1;
				if (4'(i) > ch_r) begin
					above     = 4'(i);
					has_above = 1'b1;
				end
			end
		end
	end

	always_comb begin
		ch_nxt    = ch_r;
		valid_nxt = scan_en && has_any;
		if (!scan_en || !has_any || restart) begin
			ch_nxt = lowest;
		end else if (advance || !scan_sel[ch_r]) begin
			// A deselected current channel is left at once rather than converted again
			ch_nxt = has_above ? above : lowest;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch_r    <= 4'h0;
			valid_r <= 1'b0;
		end else begin
			ch_r    <= ch_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign channel       = ch_r;
	assign channel_valid = valid_r;
endmodule // scan_sequencer

`default_nettype wire

// ===== adc_cfg_checker_assertions.sv
// Port-level assertions of the converter configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Register bus
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [31:0] readdata,
	// Digital port
	input wire logic [15:0] port_pin_in,
	input wire logic [15:0] port_read_data,
	input wire logic [15:0] digital_read_en,
	input wire logic [15:0] analog_sample_en,
	// Converter core
	input wire logic        rc_clk_tick,
	input wire logic        scan_advance,
	input wire logic        conv_clk_tick,
	input wire logic        conv_clk_source,
	input wire logic        scan_valid,
	input wire logic [3:0]  scan_channel
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_MODE_COMPL: assert property (!$past(rst) |-> analog_sample_en == ~digital_read_en)
		else $error("sample enable not inverse of read enable");
	AST_PORT_GATE: assert property (!$past(rst) |->
		port_read_data == ($past(port_pin_in) & digital_read_en))
		else $error("port read not gated by mode bits");
	AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_ACK_BOUND: assert property ((read || write) && waitrequest |-> ##[1:3] !waitrequest)
		else $error("bus access not answered");
	AST_ACK_CAUSE: assert property (!waitrequest |-> $past(read || write))
		else $error("answer without request");
	AST_RD_STABLE: assert property ($changed(readdata) |-> !waitrequest)
		else $error("read data moved outside an answer");
	AST_RC_PASS: assert property (conv_clk_source && $past(conv_clk_source) |->
		conv_clk_tick == $past(rc_clk_tick))
		else $error("conversion tick does not follow RC source");
	AST_SCAN_CAUSE: assert property ($changed(scan_channel) |-> $past(scan_advance)
		|| $past(scan_advance, 2) || $past(write) || $past(write, 2) || $past(write, 3))
		else $error("scan channel moved without cause");
	COV_READ: cover property (read && !waitrequest);
	COV_SCAN: cover property (scan_advance && scan_valid);
	COV_RC: cover property (conv_clk_source && conv_clk_tick);
endmodule // adc_cfg_checker

bind adc_cfg_top adc_cfg_checker i_chk (.ref_clk(ref_clk), .rst(rst), .read(read),
	.write(write), .waitrequest(waitrequest), .readdata(readdata), .rc_clk_tick(rc_clk_tick),
	.scan_advance(scan_advance), .conv_clk_tick(conv_clk_tick),
	.conv_clk_source(conv_clk_source), .scan_valid(scan_valid), .port_pin_in(port_pin_in),
	.port_read_data(port_read_data), .digital_read_en(digital_read_en),
	.analog_sample_en(analog_sample_en), .scan_channel(scan_channel));
`default_nettype wire

// ===== adc_core_model.sv
// Behavioural model of the converter core and the digital port pins
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// From the block
	input  wire logic        scan_valid,
	// To the block
	output var logic  [15:0] port_pin_in  = 16'h0000,
	output var logic         rc_clk_tick  = 1'b0,
	output var logic         scan_advance = 1'b0
);
	logic [3:0] cnt_r     = 4'h0;
	logic [3:0] adv_cnt_r = 4'h0;
	// Pins follow a free-running count, bits 0, 4, 8 and 12 toggling every cycle, so a stuck read path shows
	// Sample timing restarts with each scan, so the first step never lands mid-setup
	always_ff @(posedge ref_clk) begin
		cnt_r <= rst ? 4'h0 : cnt_r + 4'h1;
		adv_cnt_r <= (rst || !scan_valid) ? 4'h0 : adv_cnt_r + 4'h1;
		rc_clk_tick <= cnt_r[1:0] == 2'h3;
		scan_advance <= scan_valid && adv_cnt_r == 4'h7;
		port_pin_in <= {4{cnt_r}} ^ {8{cnt_r[0], 1'b1}};
	end
endmodule // adc_core_model
`default_nettype wire

// ===== tb_adc_cfg_top.sv
// Self-checking testbench of the converter configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_cfg_top;
	logic        ref_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic [3:0]  address = 4'h0, byteenable = 4'hf, scan_channel;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic        waitrequest, rc_clk_tick, scan_advance, conv_clk_tick, conv_clk_source, scan_valid;
	logic [15:0] port_pin_in, port_read_data, digital_read_en, analog_sample_en;
	int          fail_count = 0, n_checks = 0, p;
	always #12.5 ref_clk = ~ref_clk;
	adc_cfg_top i_dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .port_pin_in(port_pin_in), .port_read_data(port_read_data),
		.digital_read_en(digital_read_en), .rc_clk_tick(rc_clk_tick),
		.scan_advance(scan_advance), .analog_sample_en(analog_sample_en),
		.conv_clk_tick(conv_clk_tick), .conv_clk_source(conv_clk_source),
		.scan_channel(scan_channel), .scan_valid(scan_valid));
	adc_core_model i_core (.ref_clk(ref_clk), .rst(rst), .scan_valid(scan_valid),
		.port_pin_in(port_pin_in), .rc_clk_tick(rc_clk_tick), .scan_advance(scan_advance));
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task tmo;
		fail_count++;
		$display("CHECK FAILED t=%0t wait limit reached", $time);
		print_verdict;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Request held until the edge that sees waitrequest low
	task bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= we;
		read <= !we;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20) tmo();
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task per(output int n);
		int g;
		g = 0;
		n = 0;
		while (conv_clk_tick !== 1'b1 && g < 600) begin
			@(posedge ref_clk);
			g++;
		end
		do begin
			@(posedge ref_clk);
			n++;
		end while (conv_clk_tick !== 1'b1 && n < 600);
		if (g >= 600 || n >= 600) tmo();
	endtask
	task t_regs;
		bus(0, adc_cfg_pkg::PIN_MODE_ADDR, 0, q); chk(q, 32'h0);
		bus(0, adc_cfg_pkg::SCAN_SEL_ADDR, 0, q); chk(q, 32'h0);
		bus(1, adc_cfg_pkg::PIN_MODE_ADDR, 32'hffffa5c3, q);
		bus(0, adc_cfg_pkg::PIN_MODE_ADDR, 0, q); chk(q, 32'ha5c3);
		bus(1, adc_cfg_pkg::SCAN_SEL_ADDR, 32'h3c96, q);
		bus(0, adc_cfg_pkg::SCAN_SEL_ADDR, 0, q); chk(q, 32'h3c96);
		bus(1, 4'h2, 32'h1234, q);
		bus(0, 4'h2, 0, q); chk(q, 32'h0);
		bus(0, adc_cfg_pkg::PIN_MODE_ADDR, 0, q); chk(q, 32'ha5c3);
		byteenable <= 4'h1;
		bus(1, adc_cfg_pkg::PIN_MODE_ADDR, 32'hffff0000, q);
		byteenable <= 4'hf;
		bus(0, adc_cfg_pkg::PIN_MODE_ADDR, 0, q); chk(q, 32'ha500);
		$display("test regs done");
	endtask
	task t_mode;
		logic [15:0] pv;
		bus(1, adc_cfg_pkg::PIN_MODE_ADDR, 32'h8001, q);
		wt(2);
		chk(digital_read_en, 16'h8001);
		chk(analog_sample_en, 16'h7ffe);
		chk(port_read_data & 16'h7ffe, 16'h0);
		pv = port_pin_in;
		wt(1);
		chk(port_read_data, pv & 16'h8001);
		$display("test mode done");
	endtask
	task t_clk;
		logic [7:0] dv[3] = '{8'h00, 8'h02, 8'h05};
		for (int i = 0; i < 3; i++) begin
			bus(1, adc_cfg_pkg::CLK_CTRL_ADDR, {24'h0, dv[i]}, q);
			per(p);
			per(p);
			chk(p, dv[i] + 32'h1);
		end
		bus(1, adc_cfg_pkg::CLK_CTRL_ADDR, 32'h8000, q);
		bus(0, adc_cfg_pkg::CLK_CTRL_ADDR, 0, q); chk(q, 32'h8000);
		wt(3);
		chk(conv_clk_source, 1'b1);
		per(p);
		per(p);
		chk(p, 32'h4);
		bus(1, adc_cfg_pkg::CLK_CTRL_ADDR, 32'h0, q);
		wt(2);
		chk(conv_clk_source, 1'b0);
		$display("test clock done");
	endtask
	task t_scan;
		logic [3:0] ex[5] = '{4'h0, 4'h2, 4'h4, 4'hf, 4'h0};
		int g;
		bus(1, adc_cfg_pkg::SCAN_SEL_ADDR, 32'h8015, q);
		bus(1, adc_cfg_pkg::SCAN_CTRL_ADDR, 32'h1, q);
		wt(2);
		chk(scan_valid, 1'b1);
		chk(scan_channel, ex[0]);
		bus(0, adc_cfg_pkg::SCAN_CTRL_ADDR, 0, q); chk(q, 32'h3);
		for (int i = 1; i < 5; i++) begin
			g = 0;
			while (scan_advance !== 1'b1 && g < 100) begin
				@(posedge ref_clk);
				g++;
			end
			if (g >= 100) tmo();
			wt(2);
			chk(scan_channel, ex[i]);
		end
		bus(1, adc_cfg_pkg::SCAN_SEL_ADDR, 32'h0, q);
		wt(3);
		chk(scan_valid, 1'b0);
		$display("test scan done");
	endtask
	initial begin
		wt(2);
		rst <= 1'b0;
		wt(1);
		t_regs();
		t_mode();
		t_clk();
		t_scan();
		print_verdict();
	end
endmodule // tb_adc_cfg_top
`default_nettype wire
